// [irq_prio_cfg.svh]
// constants for the two-group interrupt priority enable block
// assumes an 8-bit register port with 12-bit addresses on a single system clock
`ifndef IRQ_PRIO_CFG_SVH
`define IRQ_PRIO_CFG_SVH

// widths
`define REG_ADDR_W 12
`define REG_DATA_W 8
`define SRC_PER_GROUP 8

// register offsets
`define OFS_GROUP0_ENABLE_HIGH 12'hFC1
`define OFS_GROUP0_ENABLE_LOW 12'hFC2
`define OFS_GROUP1_ENABLE_HIGH 12'hFC4
`define OFS_GROUP1_ENABLE_LOW 12'hFC5
`define OFS_PIN_PORT_SELECT 12'hFCE
`define OFS_EVENT_STATUS 12'hFD0
`define OFS_EVENT_MASK 12'hFD1
`define OFS_CHOICE_VIEW 12'hFD2

// reset values
`define ENABLE_RST 8'h00
`define PORT_SELECT_RST 8'h00
`define EVENT_RST 3'h0

// group0 source bit positions
`define BIT_TIMER2 7
`define BIT_TIMER1 6
`define BIT_TIMER0 5
`define BIT_SERIAL0_RX 4
`define BIT_SERIAL0_TX 3
`define BIT_TWOWIRE 2
`define BIT_SYNC_SERIAL 1
`define BIT_CONVERTER 0

// choice view field positions
`define VIEW_VALID_BIT 7
`define VIEW_GROUP_BIT 6
`define VIEW_INDEX_MSB 5
`define VIEW_INDEX_LSB 3
`define VIEW_LEVEL_MSB 1
`define VIEW_LEVEL_LSB 0

// event status width: one bit per priority level 1..3
`define EVENT_W 3

`endif

// [irq_prio_pkg.sv]
// types shared by the interrupt priority enable block
// assumes the constants header is on the include path
`include "irq_prio_cfg.svh"

package irq_prio_pkg;

    // two-bit priority code, high enable bit on the left
    typedef enum logic [1:0] {
        PRIO_DISABLED = 2'h0,
        PRIO_LOW = 2'h1,
        PRIO_NOMINAL = 2'h2,
        PRIO_HIGH = 2'h3
    } prio_level_e;

    // one register port access
    typedef struct packed {
        logic [`REG_ADDR_W-1:0] addr;
        logic [`REG_DATA_W-1:0] wdata;
        logic we;
        logic re;
    } reg_bus_s;

    // request presented to the cpu
    typedef struct packed {
        logic valid;
        logic group;
        logic [2:0] index;
        prio_level_e level;
    } irq_choice_s;

endpackage : irq_prio_pkg

// [prio_decode.sv]
// one source: gates a request line by its high/low enable pair
// assumes request and enables are on the same clock as the caller
`timescale 1ns/10ps
`default_nettype none

module prio_decode
    import irq_prio_pkg::*;
(
    // request and enable pair
    input wire logic req_i,
    input wire logic en_high_i,
    input wire logic en_low_i,
    // gated level
    output prio_level_e level_o
);

    // a request with both enables clear reads as disabled
    always_comb begin
        if (req_i) begin
            level_o = prio_level_e'({en_high_i, en_low_i});
        end else begin
            level_o = PRIO_DISABLED;
        end
    end

endmodule : prio_decode

`default_nettype wire

// [enable_pair.sv]
// high and low enable registers of one group
// assumes write strobes are already decoded by the caller
`timescale 1ns/10ps
`default_nettype none
`include "irq_prio_cfg.svh"

module enable_pair
    import irq_prio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // write side
    input wire logic we_high_i,
    input wire logic we_low_i,
    input wire logic [`REG_DATA_W-1:0] wdata_i,
    // register contents
    output logic [`REG_DATA_W-1:0] high_o,
    output logic [`REG_DATA_W-1:0] low_o
);

    logic [`REG_DATA_W-1:0] next_high;
    logic [`REG_DATA_W-1:0] next_low;

    // every bit is plain read/write
    always_comb begin
        next_high = we_high_i ? wdata_i : high_o;
        next_low = we_low_i ? wdata_i : low_o;
    end

    // all sources start disabled
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            high_o <= `ENABLE_RST;
            low_o <= `ENABLE_RST;
        end else begin
            high_o <= next_high;
            low_o <= next_low;
        end
    end

endmodule : enable_pair

`default_nettype wire

// [irq_prio_top.sv]
// two-group priority enable and request selection
// assumes request lines are already captured on clk_i by the request registers
// and that the register master follows the one-cycle strobe protocol
`timescale 1ns/10ps
`default_nettype none
`include "irq_prio_cfg.svh"

module irq_prio_top
    import irq_prio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire reg_bus_s bus_i,
    output logic [`REG_DATA_W-1:0] rdata_o,
    // request lines
    input wire logic [`SRC_PER_GROUP-1:0] group0_req_i,
    input wire logic [`SRC_PER_GROUP-1:0] port_a_req_i,
    input wire logic [`SRC_PER_GROUP-1:0] port_d_req_i,
    // to the cpu
    output irq_choice_s choice_o,
    output logic irq_o
);

    localparam int NSRC = `SRC_PER_GROUP;

    // register contents
    logic [`REG_DATA_W-1:0] group0_enable_high;
    logic [`REG_DATA_W-1:0] group0_enable_low;
    logic [`REG_DATA_W-1:0] group1_enable_high;
    logic [`REG_DATA_W-1:0] group1_enable_low;
    logic [`REG_DATA_W-1:0] port_select;
    logic [`REG_DATA_W-1:0] next_port_select;
    logic [`EVENT_W-1:0] event_status;
    logic [`EVENT_W-1:0] next_event_status;
    logic [`EVENT_W-1:0] event_mask;
    logic [`EVENT_W-1:0] next_event_mask;
    logic [`REG_DATA_W-1:0] next_rdata;

    // write decode
    logic wr_g0_high;
    logic wr_g0_low;
    logic wr_g1_high;
    logic wr_g1_low;
    logic wr_select;
    logic wr_status;
    logic wr_mask;

    // request path
    logic [NSRC-1:0] pin_req;
    prio_level_e g0_level [NSRC];
    prio_level_e g1_level [NSRC];
    irq_choice_s pick;
    irq_choice_s next_choice;
    logic [`EVENT_W-1:0] level_any;
    logic [`EVENT_W-1:0] level_any_prev;
    logic [`EVENT_W-1:0] next_level_any_prev;
    logic [`EVENT_W-1:0] level_event;

    // write strobes, one per writable register; unmapped writes touch nothing
    always_comb begin
        wr_g0_high = bus_i.we && (bus_i.addr == `OFS_GROUP0_ENABLE_HIGH);
        wr_g0_low = bus_i.we && (bus_i.addr == `OFS_GROUP0_ENABLE_LOW);
        wr_g1_high = bus_i.we && (bus_i.addr == `OFS_GROUP1_ENABLE_HIGH);
        wr_g1_low = bus_i.we && (bus_i.addr == `OFS_GROUP1_ENABLE_LOW);
        wr_select = bus_i.we && (bus_i.addr == `OFS_PIN_PORT_SELECT);
        wr_status = bus_i.we && (bus_i.addr == `OFS_EVENT_STATUS);
        wr_mask = bus_i.we && (bus_i.addr == `OFS_EVENT_MASK);
    end

    // group 0 enables: peripheral sources
    enable_pair u_group0_enable (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .we_high_i(wr_g0_high),
        .we_low_i(wr_g0_low),
        .wdata_i(bus_i.wdata),
        .high_o(group0_enable_high),
        .low_o(group0_enable_low)
    );

    // group 1 enables: pin sources
    enable_pair u_group1_enable (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .we_high_i(wr_g1_high),
        .we_low_i(wr_g1_low),
        .wdata_i(bus_i.wdata),
        .high_o(group1_enable_high),
        .low_o(group1_enable_low)
    );

    // pin slot source: select bit high takes port d, low takes port a;
    // the enables never enter here, so disabling a slot keeps its source
    always_comb begin
        pin_req = (port_d_req_i & port_select) | (port_a_req_i & ~port_select);
    end

    // per-source gating, bit x of both enables paired with request bit x;
    // group 0 bit order: timer2 timer1 timer0 rx tx twowire sync_serial converter
    for (genvar gi = 0; gi < NSRC; gi++) begin : g_src
        prio_decode u_g0 (
            .req_i(group0_req_i[gi]),
            .en_high_i(group0_enable_high[gi]),
            .en_low_i(group0_enable_low[gi]),
            .level_o(g0_level[gi])
        );
        prio_decode u_g1 (
            .req_i(pin_req[gi]),
            .en_high_i(group1_enable_high[gi]),
            .en_low_i(group1_enable_low[gi]),
            .level_o(g1_level[gi])
        );
    end

    // selection: strictly higher level wins, so on a tie the earlier
    // scan position stays: group 0 before group 1, bit 7 down to bit 0
    always_comb begin
        pick = '0;
        pick.level = PRIO_DISABLED;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (g0_level[i] > pick.level) begin
                pick.valid = 1'b1;
                pick.group = 1'b0;
                pick.index = 3'(i);
                pick.level = g0_level[i];
            end
        end
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (g1_level[i] > pick.level) begin
                pick.valid = 1'b1;
                pick.group = 1'b1;
                pick.index = 3'(i);
                pick.level = g1_level[i];
            end
        end
    end

    // which levels have at least one enabled pending request
    always_comb begin
        level_any = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (g0_level[i] != PRIO_DISABLED) begin
                level_any[g0_level[i] - 2'h1] = 1'b1;
            end
            if (g1_level[i] != PRIO_DISABLED) begin
                level_any[g1_level[i] - 2'h1] = 1'b1;
            end
        end
        level_event = level_any & ~level_any_prev;
        next_level_any_prev = level_any;
    end

    // sticky status: a new event in the clearing cycle survives the clear
    always_comb begin
        next_event_status = event_status;
        if (wr_status) begin
            next_event_status = event_status & ~bus_i.wdata[`EVENT_W-1:0];
        end
        next_event_status = next_event_status | level_event;
        next_event_mask = wr_mask ? bus_i.wdata[`EVENT_W-1:0] : event_mask;
        next_port_select = wr_select ? bus_i.wdata : port_select;
        next_choice = pick;
    end

    // read mux: data only in the cycle after the strobe, zero elsewhere
    always_comb begin
        next_rdata = '0;
        if (bus_i.re) begin
            case (bus_i.addr)
                `OFS_GROUP0_ENABLE_HIGH: next_rdata = group0_enable_high;
                `OFS_GROUP0_ENABLE_LOW: next_rdata = group0_enable_low;
                `OFS_GROUP1_ENABLE_HIGH: next_rdata = group1_enable_high;
                `OFS_GROUP1_ENABLE_LOW: next_rdata = group1_enable_low;
                `OFS_PIN_PORT_SELECT: next_rdata = port_select;
                `OFS_EVENT_STATUS: next_rdata = {5'h00, event_status};
                `OFS_EVENT_MASK: next_rdata = {5'h00, event_mask};
                `OFS_CHOICE_VIEW: begin
                    next_rdata[`VIEW_VALID_BIT] = choice_o.valid;
                    next_rdata[`VIEW_GROUP_BIT] = choice_o.group;
                    next_rdata[`VIEW_INDEX_MSB:`VIEW_INDEX_LSB] = choice_o.index;
                    next_rdata[`VIEW_LEVEL_MSB:`VIEW_LEVEL_LSB] = choice_o.level;
                end
                default: next_rdata = '0;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_select <= `PORT_SELECT_RST;
            event_status <= `EVENT_RST;
            event_mask <= `EVENT_RST;
            level_any_prev <= `EVENT_RST;
            rdata_o <= '0;
            choice_o <= '0;
        end else begin
            port_select <= next_port_select;
            event_status <= next_event_status;
            event_mask <= next_event_mask;
            level_any_prev <= next_level_any_prev;
            rdata_o <= next_rdata;
            choice_o <= next_choice;
        end
    end

    // level interrupt, high while any unmasked event bit is set
    assign irq_o = |(event_status & event_mask);

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_group0_gate_code: assert property (
        pick.valid && !pick.group |->
        {group0_enable_high[pick.index], group0_enable_low[pick.index]} == pick.level
        && group0_req_i[pick.index])
        else $error("group0 pick level differs from its enable pair");

    a_group1_gate_code: assert property (
        pick.valid && pick.group |->
        {group1_enable_high[pick.index], group1_enable_low[pick.index]} == pick.level)
        else $error("group1 pick level differs from its enable pair");

    a_disabled_never_picked: assert property (
        pick.valid == (pick.level != PRIO_DISABLED))
        else $error("pick valid disagrees with level");

    a_timer2_high_map: assert property (
        group0_req_i[`BIT_TIMER2] && group0_enable_high[`BIT_TIMER2] && group0_enable_low[`BIT_TIMER2]
        |-> pick.valid && pick.level == PRIO_HIGH && !pick.group && pick.index == 3'h7)
        else $error("timer2 at high level not chosen");

    a_serial_rx_map: assert property (
        group0_req_i[`BIT_SERIAL0_RX] && group0_enable_high[`BIT_SERIAL0_RX]
        && group0_enable_low[`BIT_SERIAL0_RX] |=> choice_o.level == PRIO_HIGH)
        else $error("serial rx at high level not presented");

    a_converter_low_map: assert property (
        group0_req_i[`BIT_CONVERTER] && !group0_enable_high[`BIT_CONVERTER]
        && group0_enable_low[`BIT_CONVERTER] |-> pick.valid && pick.level >= PRIO_LOW)
        else $error("converter at low level not seen");

    a_pin_slot_source: assert property (
        pick.valid && pick.group |-> pin_req[pick.index])
        else $error("group1 pick without pin request");

    // slot 2 is the one the bench moves between ports
    a_port_select_mux: assert property (
        pin_req[2] == (port_select[2] ? port_d_req_i[2] : port_a_req_i[2]))
        else $error("pin slot 2 ignores port select");

    a_enable_write_back: assert property (
        wr_g1_low |=> group1_enable_low == $past(bus_i.wdata)
        ##1 (!($past(bus_i.re) && $past(bus_i.addr) == `OFS_GROUP1_ENABLE_LOW && !$past(wr_g1_low))
        || rdata_o == group1_enable_low))
        else $error("enable register write not held or read back");

    a_highest_first: assert property (
        level_any[2] |=> choice_o.valid && choice_o.level == PRIO_HIGH)
        else $error("high level request not presented first");

    a_read_one_cycle: assert property (
        !bus_i.re |=> rdata_o == '0)
        else $error("read data outside the answer cycle");

    a_irq_follows_mask: assert property (
        level_event[2] && event_mask[2] && !wr_mask |=> irq_o)
        else $error("unmasked event did not raise the interrupt");

    // sticky bits only fall on a one written to them
    a_status_sticky: assert property (
        event_status[2] && !(wr_status && bus_i.wdata[2]) |=> event_status[2])
        else $error("level3 event bit lost without a clear");

    a_status_clear: assert property (
        wr_status && bus_i.wdata[2] && !level_event[2] |=> !event_status[2])
        else $error("level3 event bit survived its clear");

    c_high_over_low: cover property (level_any[2] && level_any[0] ##1 choice_o.level == PRIO_HIGH);
    c_pin_from_port_d: cover property (pick.valid && pick.group && port_select[pick.index]);
    c_clear_meets_set: cover property (wr_status && |(bus_i.wdata[`EVENT_W-1:0] & level_event));
    c_masked_event: cover property (level_event[0] && !event_mask[0]);

endmodule : irq_prio_top

`default_nettype wire

// [irq_prio_top_dummy_end.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [irq_source_model.sv]
// far-side model: the peripheral and pin request sources feeding the block
// assumes the bench loads new request levels with a one-cycle load pulse
`timescale 1ns/10ps
`default_nettype none

module irq_source_model
    import irq_prio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // load side from the bench
    input wire logic load_i,
    input wire logic [7:0] group0_i,
    input wire logic [7:0] port_a_i,
    input wire logic [7:0] port_d_i,
    // request levels towards the block
    output logic [7:0] group0_o,
    output logic [7:0] port_a_o,
    output logic [7:0] port_d_o
);
    // sources hold their request level until told otherwise, like captured request flags
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            group0_o <= 8'h00;
            port_a_o <= 8'h00;
            port_d_o <= 8'h00;
        end else if (load_i) begin
            group0_o <= group0_i;
            port_a_o <= port_a_i;
            port_d_o <= port_d_i;
        end
    end
endmodule : irq_source_model

`default_nettype wire

// [irq_prio_top_test.sv]
// self-checking bench for the two-group priority enable block
// assumes the source model file and the design files are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "irq_prio_cfg.svh"

module irq_prio_top_test;
    import irq_prio_pkg::*;
    logic clk_i;
    logic sys_rst_i;
    reg_bus_s bus;
    logic [7:0] rdata_o;
    irq_choice_s choice_o;
    logic irq_o;
    logic load;
    logic [7:0] g0_set, pa_set, pd_set, g0_req, pa_req, pd_req;
    int failures = 0;
    int comparisons = 0;

    irq_source_model src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_i(load), .group0_i(g0_set),
        .port_a_i(pa_set), .port_d_i(pd_set), .group0_o(g0_req), .port_a_o(pa_req), .port_d_o(pd_req));
    irq_prio_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata_o),
        .group0_req_i(g0_req), .port_a_req_i(pa_req), .port_d_req_i(pd_req), .choice_o(choice_o), .irq_o(irq_o));

    // 125 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // an idle choice only promises a low valid bit, so the other fields are not judged then
    task automatic chk_choice(input string what, input logic v, input logic g, input logic [2:0] i, input logic [1:0] l);
        @(posedge clk_i);
        #1;
        if (v)
            chk(what, {1'b0, v, g, i, l}, {1'b0, choice_o});
        else
            chk(what, 8'h00, {7'h00, choice_o.valid});
    endtask : chk_choice

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.we <= 1'b1;
        @(posedge clk_i);
        bus.we <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus.addr <= a;
        bus.re <= 1'b1;
        @(posedge clk_i);
        bus.re <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask : rd_chk

    // the source model latches at the edge where this task returns
    task automatic set_req(input logic [7:0] g0, input logic [7:0] pa, input logic [7:0] pd);
        @(posedge clk_i);
        load <= 1'b1;
        g0_set <= g0;
        pa_set <= pa;
        pd_set <= pd;
        @(posedge clk_i);
        load <= 1'b0;
    endtask : set_req

    task automatic test_reset_values;
        rd_chk("g0 high", `OFS_GROUP0_ENABLE_HIGH, 8'h00);
        rd_chk("g0 low", `OFS_GROUP0_ENABLE_LOW, 8'h00);
        rd_chk("g1 high", `OFS_GROUP1_ENABLE_HIGH, 8'h00);
        rd_chk("g1 low", `OFS_GROUP1_ENABLE_LOW, 8'h00);
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_read_write;
        wr(`OFS_GROUP0_ENABLE_HIGH, 8'hA5);
        wr(`OFS_GROUP0_ENABLE_LOW, 8'h5A);
        wr(`OFS_GROUP1_ENABLE_HIGH, 8'hC3);
        wr(`OFS_GROUP1_ENABLE_LOW, 8'h3C);
        wr(12'hFC3, 8'hFF);
        rd_chk("g0 high rw", `OFS_GROUP0_ENABLE_HIGH, 8'hA5);
        rd_chk("g0 low rw", `OFS_GROUP0_ENABLE_LOW, 8'h5A);
        rd_chk("g1 high rw", `OFS_GROUP1_ENABLE_HIGH, 8'hC3);
        rd_chk("g1 low rw", `OFS_GROUP1_ENABLE_LOW, 8'h3C);
        rd_chk("unmapped", 12'hFC3, 8'h00);
        wr(`OFS_GROUP1_ENABLE_HIGH, 8'h00);
        wr(`OFS_GROUP1_ENABLE_LOW, 8'h00);
        $display("test read_write done");
    endtask : test_read_write

    // every code on the timer 2 slot, the top group-0 bit
    task automatic test_code_decode;
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_GROUP0_ENABLE_HIGH, {c[1], 7'h00});
            wr(`OFS_GROUP0_ENABLE_LOW, {c[0], 7'h00});
            set_req(8'h80, 8'h00, 8'h00);
            chk_choice("code decode", c != 0, 1'b0, 3'h7, c[1:0]);
        end
        $display("test code_decode done");
    endtask : test_code_decode

    // all requests up, one slot enabled: only its own pair may pass it
    task automatic test_bit_pairing;
        for (int x = 0; x < 8; x++) begin
            wr(`OFS_GROUP0_ENABLE_HIGH, 8'h01 << x);
            wr(`OFS_GROUP0_ENABLE_LOW, 8'h01 << x);
            set_req(8'hFF, 8'h00, 8'h00);
            chk_choice("bit pairing", 1'b1, 1'b0, x[2:0], 2'h3);
        end
        wr(`OFS_GROUP0_ENABLE_HIGH, 8'h00);
        wr(`OFS_GROUP0_ENABLE_LOW, 8'h00);
        $display("test bit_pairing done");
    endtask : test_bit_pairing

    task automatic test_pin_port;
        wr(`OFS_GROUP1_ENABLE_HIGH, 8'h04);
        set_req(8'h00, 8'h04, 8'h00);
        chk_choice("pin via port a", 1'b1, 1'b1, 3'h2, 2'h2);
        wr(`OFS_PIN_PORT_SELECT, 8'h04);
        chk_choice("port d idle", 1'b0, 1'b1, 3'h2, 2'h2);
        set_req(8'h00, 8'h04, 8'h04);
        chk_choice("pin via port d", 1'b1, 1'b1, 3'h2, 2'h2);
        rd_chk("enable kept", `OFS_GROUP1_ENABLE_HIGH, 8'h04);
        rd_chk("port select", `OFS_PIN_PORT_SELECT, 8'h04);
        wr(`OFS_PIN_PORT_SELECT, 8'h00);
        $display("test pin_port done");
    endtask : test_pin_port

    task automatic test_priority;
        wr(`OFS_GROUP0_ENABLE_HIGH, 8'h02);
        wr(`OFS_GROUP1_ENABLE_HIGH, 8'h20);
        wr(`OFS_GROUP1_ENABLE_LOW, 8'h20);
        set_req(8'h02, 8'h20, 8'h00);
        chk_choice("higher level wins", 1'b1, 1'b1, 3'h5, 2'h3);
        wr(`OFS_GROUP1_ENABLE_LOW, 8'h00);
        chk_choice("tie group0 first", 1'b1, 1'b0, 3'h1, 2'h2);
        wr(`OFS_GROUP0_ENABLE_HIGH, 8'h42);
        set_req(8'h42, 8'h20, 8'h00);
        chk_choice("tie high bit first", 1'b1, 1'b0, 3'h6, 2'h2);
        rd_chk("choice view", `OFS_CHOICE_VIEW, 8'hB2);
        wr(`OFS_GROUP0_ENABLE_HIGH, 8'h00);
        wr(`OFS_GROUP1_ENABLE_HIGH, 8'h00);
        $display("test priority done");
    endtask : test_priority

    // earlier tests leave sticky events behind, so start from a clean status
    task automatic test_interrupt;
        set_req(8'h00, 8'h00, 8'h00);
        wr(`OFS_EVENT_STATUS, 8'h07);
        rd_chk("status clear", `OFS_EVENT_STATUS, 8'h00);
        wr(`OFS_EVENT_MASK, 8'h04);
        rd_chk("mask", `OFS_EVENT_MASK, 8'h04);
        wr(`OFS_GROUP0_ENABLE_HIGH, 8'h40);
        wr(`OFS_GROUP0_ENABLE_LOW, 8'h40);
        set_req(8'h40, 8'h00, 8'h00);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq raised", 8'h01, {7'h00, irq_o});
        rd_chk("level3 event", `OFS_EVENT_STATUS, 8'h04);
        wr(`OFS_EVENT_STATUS, 8'h04);
        chk("irq cleared", 8'h00, {7'h00, irq_o});
        wr(`OFS_GROUP0_ENABLE_LOW, 8'h41);
        set_req(8'h41, 8'h00, 8'h00);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq masked", 8'h00, {7'h00, irq_o});
        rd_chk("level1 event", `OFS_EVENT_STATUS, 8'h01);
        $display("test interrupt done");
    endtask : test_interrupt

    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // the whole sequence needs well under 2000 cycles
    initial begin
        #200000;
        failures++;
        close_out();
    end

    initial begin
        bus = '0;
        load = 1'b0;
        g0_set = 8'h00;
        pa_set = 8'h00;
        pd_set = 8'h00;
        sys_rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        test_reset_values();
        test_read_write();
        test_code_decode();
        test_bit_pairing();
        test_pin_port();
        test_priority();
        test_interrupt();
        close_out();
    end
endmodule : irq_prio_top_test

`default_nettype wire
